// *** hdl/t1ec_map.svh ***
// Register offsets, field positions, reset values and counts of the receive error counters.
// Assumes an 8-bit register port whose addresses are the printed byte offsets.
`ifndef T1EC_MAP_SVH
`define T1EC_MAP_SVH

`define T1EC_ADDR_W 8
`define T1EC_DATA_W 8

`define T1EC_OFF_LINE_HIGH 8'h23
`define T1EC_OFF_LINE_LOW 8'h24
`define T1EC_OFF_PATH_MF_HIGH 8'h25
`define T1EC_OFF_PATH_LOW 8'h26
`define T1EC_OFF_MF_LOW 8'h27
`define T1EC_OFF_CONTROL 8'h2B
`define T1EC_OFF_INT_STATUS 8'h2C
`define T1EC_OFF_INT_MASK 8'h2D

`define T1EC_CTRL_EXCESS_ZERO 0
`define T1EC_CTRL_B8ZS 1
`define T1EC_CTRL_ESF 2
`define T1EC_CTRL_FS_ERROR 3
`define T1EC_CTRL_MF_SELECT 4
`define T1EC_CTRL_W 5
`define T1EC_CTRL_RESET 5'h10

`define T1EC_INT_SECOND 0
`define T1EC_INT_LINE_SAT 1
`define T1EC_INT_PATH_SAT 2
`define T1EC_INT_MF_SAT 3
`define T1EC_INT_W 4
`define T1EC_INT_RESET 4'h0

`define T1EC_LINE_W 16
`define T1EC_PATH_W 12
`define T1EC_MF_W 12
`define T1EC_ZRUN_W 5
`define T1EC_ZEROS_PLAIN 5'h10
`define T1EC_ZEROS_B8ZS 5'h08

`endif

// *** hdl/t1ec_pkg.sv ***
// Types shared by the receive error counters.
// Widths come from the constant header.
`include "t1ec_map.svh"

package t1ec_pkg;

    // Event strobes from the receive line decoder and framer, one cycle each
    typedef struct packed {
        logic bpv;
        logic b8zs_codeword;
        logic bit_valid;
        logic bit_value;
        logic crc_error;
        logic ft_error;
        logic fs_error;
        logic fps_error;
        logic multiframe;
        logic one_second;
    } t1ec_events_t;

    typedef struct packed {
        logic mf_select;
        logic fs_error_count_enable;
        logic esf_framing_select;
        logic b8zs_receive_enable;
        logic excess_zero_count_enable;
    } t1ec_ctrl_t;

    typedef struct packed {
        logic [`T1EC_LINE_W-1:0] line_acc;
        logic [`T1EC_PATH_W-1:0] path_acc;
        logic [`T1EC_MF_W-1:0] mf_acc;
        logic [`T1EC_LINE_W-1:0] line_count;
        logic [`T1EC_PATH_W-1:0] path_count;
        logic [`T1EC_MF_W-1:0] mf_count;
        logic [`T1EC_ZRUN_W-1:0] zero_run;
        t1ec_ctrl_t ctrl;
        logic [`T1EC_INT_W-1:0] int_status;
        logic [`T1EC_INT_W-1:0] int_mask;
        logic [`T1EC_DATA_W-1:0] rd_data;
        logic irq;
    } t1ec_state_t;

endpackage : t1ec_pkg

// *** hdl/t1ec_counters.sv ***
// Receive performance counters: line, path and multiframe/framing error counts.
// Assumes event strobes and the sync-lost level come from logic on ref_clk.
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`include "t1ec_map.svh"

module t1ec_counters
    import t1ec_pkg::*;
(
    input wire logic ref_clk, // 250 MHz clock
    input wire logic rst_n, // Synchronous reset
    input wire logic clk_en, // Freezes all state while low
    input wire t1ec_events_t events, // Decoder and framer strobes
    input wire logic receive_sync_lost, // Receive synchronizer out of sync
    input wire logic [`T1EC_ADDR_W-1:0] addr, // Register address
    input wire logic [`T1EC_DATA_W-1:0] wr_data, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [`T1EC_DATA_W-1:0] rd_data, // Read data, cycle after strobe
    output logic irq // Level interrupt
);

    t1ec_state_t st;
    t1ec_state_t next_st;

    function automatic logic [`T1EC_LINE_W-1:0] sat_inc16(
        input logic [`T1EC_LINE_W-1:0] v,
        input logic inc
    );
        if (inc && (v != {`T1EC_LINE_W{1'b1}})) begin
            sat_inc16 = v + 16'h0001;
        end else begin
            sat_inc16 = v;
        end
    endfunction : sat_inc16

    function automatic logic [`T1EC_PATH_W-1:0] sat_inc12(
        input logic [`T1EC_PATH_W-1:0] v,
        input logic inc
    );
        if (inc && (v != {`T1EC_PATH_W{1'b1}})) begin
            sat_inc12 = v + 12'h001;
        end else begin
            sat_inc12 = v;
        end
    endfunction : sat_inc12

    logic bpv_counted;
    logic zero_event;
    logic line_inc;
    logic path_inc;
    logic mf_inc;
    logic [`T1EC_ZRUN_W-1:0] zero_limit;
    logic [`T1EC_LINE_W-1:0] line_sum;
    logic [`T1EC_PATH_W-1:0] path_sum;
    logic [`T1EC_MF_W-1:0] mf_sum;
    logic [`T1EC_INT_W-1:0] int_events;
    logic [`T1EC_INT_W-1:0] int_clear;

    always_comb begin
        next_st = st;
        // Substitution code words carry intentional violations
        bpv_counted = events.bpv &&
            !(st.ctrl.b8zs_receive_enable && events.b8zs_codeword);
        zero_limit = st.ctrl.b8zs_receive_enable ? `T1EC_ZEROS_B8ZS
                                                 : `T1EC_ZEROS_PLAIN;
        zero_event = 1'b0;
        if (events.bit_valid) begin
            if (events.bit_value) begin
                next_st.zero_run = '0;
            end else if (st.zero_run + 5'h01 == zero_limit) begin
                // Each full run counts once, then a new run starts
                zero_event = st.ctrl.excess_zero_count_enable;
                next_st.zero_run = '0;
            end else begin
                next_st.zero_run = st.zero_run + 5'h01;
            end
        end
        // No sync gating on the line counter
        line_inc = bpv_counted || zero_event;

        if (receive_sync_lost) begin
            path_inc = 1'b0;
        end else if (st.ctrl.esf_framing_select) begin
            path_inc = events.crc_error;
        end else begin
            path_inc = events.ft_error ||
                (st.ctrl.fs_error_count_enable && events.fs_error);
        end

        if (st.ctrl.mf_select) begin
            mf_inc = events.multiframe && receive_sync_lost;
        end else if (receive_sync_lost) begin
            mf_inc = 1'b0;
        end else begin
            mf_inc = st.ctrl.esf_framing_select ? events.fps_error
                                                : events.ft_error;
        end

        line_sum = sat_inc16(st.line_acc, line_inc);
        path_sum = sat_inc12(st.path_acc, path_inc);
        mf_sum = sat_inc12(st.mf_acc, mf_inc);

        if (events.one_second) begin
            next_st.line_count = line_sum;
            next_st.path_count = path_sum;
            next_st.mf_count = mf_sum;
            next_st.line_acc = '0;
            next_st.path_acc = '0;
            next_st.mf_acc = '0;
        end else begin
            next_st.line_acc = line_sum;
            next_st.path_acc = path_sum;
            next_st.mf_acc = mf_sum;
        end

        int_events = '0;
        int_events[`T1EC_INT_SECOND] = events.one_second;
        int_events[`T1EC_INT_LINE_SAT] = line_inc && (st.line_acc == {`T1EC_LINE_W{1'b1}});
        int_events[`T1EC_INT_PATH_SAT] = path_inc && (st.path_acc == {`T1EC_PATH_W{1'b1}});
        int_events[`T1EC_INT_MF_SAT] = mf_inc && (st.mf_acc == {`T1EC_MF_W{1'b1}});

        int_clear = '0;
        if (wr_en) begin
            case (addr)
                `T1EC_OFF_CONTROL: begin
                    next_st.ctrl = wr_data[`T1EC_CTRL_W-1:0];
                end
                `T1EC_OFF_INT_STATUS: begin
                    int_clear = wr_data[`T1EC_INT_W-1:0];
                end
                `T1EC_OFF_INT_MASK: begin
                    next_st.int_mask = wr_data[`T1EC_INT_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over a write-one clear in the same cycle
        next_st.int_status = (st.int_status & ~int_clear) | int_events;
        next_st.irq = |(next_st.int_status & next_st.int_mask);

        next_st.rd_data = '0;
        if (rd_en) begin
            case (addr)
                `T1EC_OFF_LINE_HIGH: next_st.rd_data = st.line_count[15:8];
                `T1EC_OFF_LINE_LOW: next_st.rd_data = st.line_count[7:0];
                `T1EC_OFF_PATH_MF_HIGH: begin
                    next_st.rd_data = {st.mf_count[11:8], st.path_count[11:8]};
                end
                `T1EC_OFF_PATH_LOW: next_st.rd_data = st.path_count[7:0];
                `T1EC_OFF_MF_LOW: next_st.rd_data = st.mf_count[7:0];
                `T1EC_OFF_CONTROL: next_st.rd_data = {3'h0, st.ctrl};
                `T1EC_OFF_INT_STATUS: next_st.rd_data = {4'h0, st.int_status};
                `T1EC_OFF_INT_MASK: next_st.rd_data = {4'h0, st.int_mask};
                default: next_st.rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.ctrl <= `T1EC_CTRL_RESET;
            st.int_status <= `T1EC_INT_RESET;
            st.int_mask <= `T1EC_INT_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign irq = st.irq;

endmodule : t1ec_counters

// *** verif/t1ec_framer_model.sv ***
// Stand-in for the receive line decoder and framer synchronizer.
// Assumes one bench process calls its tasks; strobes change after ref_clk edges.
`timescale 1ns/100ps
module t1ec_framer_model
    import t1ec_pkg::*;
(
    input wire logic ref_clk, // Clock
    output t1ec_events_t events, // Strobes
    output logic receive_sync_lost // Sync lost level
);
    initial begin
        events = '0;
        receive_sync_lost = 1'b0;
    end
    // Holds one strobe set for n cycles, then drops it
    task automatic send(input t1ec_events_t e, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            events <= e;
        end
        @(posedge ref_clk);
        events <= '0;
    endtask : send
    // A one bit ends any earlier zero run before the n zeros
    task automatic zeros(input int n);
        send('{bit_valid: 1'b1, bit_value: 1'b1, default: 1'b0}, 1);
        send('{bit_valid: 1'b1, default: 1'b0}, n);
    endtask : zeros
    task automatic sync(input logic v);
        @(posedge ref_clk);
        receive_sync_lost <= v;
    endtask : sync
endmodule : t1ec_framer_model

// *** verif/t1ec_counters_properties.sv ***
// Port-level checks of the receive error counters.
// Assumes one clock, ref_clk, with synchronous active-low rst_n.
`timescale 1ns/100ps
module t1ec_counters_properties
    import t1ec_pkg::*;
(
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic clk_en, // Enable
    input wire t1ec_events_t events, // Strobes
    input wire logic receive_sync_lost, // Sync lost
    input wire logic [7:0] addr, // Address
    input wire logic [7:0] wr_data, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    input wire logic [7:0] rd_data, // Read data
    input wire logic irq // Interrupt
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic cause = wr_en | (|events);
    chk_read_quiet: assert property (clk_en && !rd_en |=> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    chk_read_steady: assert property ((clk_en && rd_en && !events.one_second) ##1
        (clk_en && !wr_en && !events.one_second) ##1
        (clk_en && rd_en && addr == $past(addr, 2) && !events.one_second)
        |=> rd_data == $past(rd_data, 2))
        else $error("register changed without a latch");
    chk_hole_zero: assert property (clk_en && rd_en && addr == 8'h28
        |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    chk_ctrl_back: assert property (clk_en && wr_en && addr == 8'h2B ##1 clk_en && !wr_en
        ##1 clk_en && rd_en && addr == 8'h2B |=> rd_data[4:0] == $past(wr_data[4:0], 3))
        else $error("control readback wrong");
    chk_mask_off: assert property (clk_en && wr_en && addr == 8'h2D
        && wr_data[3:0] == 4'h0 |=> !irq)
        else $error("irq high with mask cleared");
    chk_irq_sticky: assert property (irq && clk_en && !wr_en |=> irq)
        else $error("irq fell without a write");
    chk_irq_cause: assert property ($rose(irq) |-> $past(cause) && $past(clk_en))
        else $error("irq rose without a cause");
    chk_freeze_all: assert property (!clk_en |=> $stable(rd_data) && $stable(irq))
        else $error("outputs moved while disabled");
endmodule : t1ec_counters_properties
bind t1ec_counters t1ec_counters_properties u_props (.ref_clk, .rst_n, .clk_en, .events,
    .receive_sync_lost, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq);

// *** verif/t1ec_counters_tb_top.sv ***
// Bench for the receive error counters: counts read back after each latch.
// Assumes the framer model supplies strobes and sync state.
`timescale 1ns/100ps
module t1ec_counters_tb_top;
    import t1ec_pkg::*;
    localparam t1ec_events_t BPV = '{bpv: 1'b1, default: 1'b0};
    localparam t1ec_events_t CW = '{bpv: 1'b1, b8zs_codeword: 1'b1, default: 1'b0};
    localparam t1ec_events_t CRC = '{crc_error: 1'b1, default: 1'b0};
    localparam t1ec_events_t FT = '{ft_error: 1'b1, default: 1'b0};
    localparam t1ec_events_t FS = '{fs_error: 1'b1, default: 1'b0};
    localparam t1ec_events_t FPS = '{fps_error: 1'b1, default: 1'b0};
    localparam t1ec_events_t MF = '{multiframe: 1'b1, default: 1'b0};
    localparam t1ec_events_t SEC = '{one_second: 1'b1, default: 1'b0};
    logic ref_clk;
    logic rst_n;
    logic clk_en;
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic irq;
    logic receive_sync_lost;
    t1ec_events_t events;
    int fail_count = 0;
    int total_checks = 0;
    t1ec_framer_model m (.ref_clk, .events, .receive_sync_lost);
    t1ec_counters u_dut (.ref_clk, .rst_n, .clk_en, .events, .receive_sync_lost, .addr,
        .wr_data, .wr_en, .rd_en, .rd_data, .irq);
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic cmp(input logic [7:0] exp, input logic [7:0] act);
        total_checks++;
        if (act !== exp) begin
            fail_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask : cmp
    task automatic cmp_irq(input logic exp);
        total_checks++;
        if (irq !== exp) begin
            fail_count++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, irq);
        end
    endtask : cmp_irq
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 cmp(exp, rd_data);
    endtask : rd
    // Latch one second, then read all five count registers
    task automatic sec(input logic [15:0] l, input logic [11:0] p, input logic [11:0] f);
        m.send(SEC, 1);
        rd(8'h23, l[15:8]);
        rd(8'h24, l[7:0]);
        rd(8'h25, {f[11:8], p[11:8]});
        rd(8'h26, p[7:0]);
        rd(8'h27, f[7:0]);
    endtask : sec
    initial begin
        #60000;
        fail_count++;
        stop_test();
    end
    initial begin
        rst_n <= 1'b0;
        clk_en <= 1'b1;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        addr <= 8'h00;
        wr_data <= 8'h00;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(8'h2B, 8'h10);
        rd(8'h2B, 8'h10);
        rd(8'h28, 8'h00);
        sec(16'h0000, 12'h000, 12'h000);
        wr(8'h2B, 8'h00);
        rd(8'h2B, 8'h00);
        m.sync(1'b1);
        m.send(BPV, 3);
        m.send(CW, 1);
        m.zeros(16);
        m.send(FT, 2);
        m.send(MF, 1);
        sec(16'h0004, 12'h000, 12'h000);
        m.sync(1'b0);
        wr(8'h2B, 8'h01);
        m.zeros(33);
        m.send(BPV, 1);
        m.send(FT, 2);
        m.send(FS, 1);
        m.send(FPS, 1);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        m.send(BPV, 2);
        clk_en <= 1'b1;
        sec(16'h0003, 12'h002, 12'h002);
        wr(8'h2B, 8'h0F);
        m.zeros(16);
        m.send(CW, 2);
        m.send(BPV, 1);
        m.send(CRC, 3);
        m.send(FT, 1);
        m.send(FPS, 2);
        sec(16'h0003, 12'h003, 12'h002);
        wr(8'h2B, 8'h18);
        m.send(FT, 1);
        m.send(FS, 1);
        m.send(MF, 1);
        m.sync(1'b1);
        m.send(MF, 2);
        m.send(FT, 1);
        sec(16'h0000, 12'h002, 12'h002);
        m.sync(1'b0);
        wr(8'h2B, 8'h04);
        wr(8'h2C, 8'h0F);
        wr(8'h2D, 8'h04);
        m.send(CRC, 4100);
        #1 cmp_irq(1'b1);
        rd(8'h2C, 8'h04);
        wr(8'h2D, 8'h00);
        #1 cmp_irq(1'b0);
        wr(8'h2D, 8'h04);
        #1 cmp_irq(1'b1);
        rd(8'h2D, 8'h04);
        wr(8'h2C, 8'h04);
        #1 cmp_irq(1'b0);
        sec(16'h0000, 12'hFFF, 12'h000);
        rd(8'h2C, 8'h01);
        cmp_irq(1'b0);
        stop_test();
    end
endmodule : t1ec_counters_tb_top
